// file: hw/bmr_defines.svh
// Contract
// R1: Energy is signed 64-bit, high word first
// R2: Fixed window updates power demand at close
// R3: Sliding window refreshes power demand every 15 s
// R4: Line-neutral voltages, phase powers need type 40/41
// R5: Neutral current demand valid only for 30/41
// R6: Power sign follows power-sign configuration setting
// R7: Maxima hold highest value since reset command
// R8: Float takes two words, read coherently together
`ifndef BMR_DEFINES_SVH
`define BMR_DEFINES_SVH

// Map limits
`define BMR_ADDR_FIRST 16'h7d37
`define BMR_ADDR_LAST 16'h7dcc

// Voltages
`define BMR_VOLTAGE_L1_L2 16'h7d37
`define BMR_VOLTAGE_L2_L3 16'h7d39
`define BMR_VOLTAGE_L3_L1 16'h7d3b
`define BMR_VOLTAGE_L1_NEUTRAL 16'h7d3d
`define BMR_VOLTAGE_L2_NEUTRAL 16'h7d3f
`define BMR_VOLTAGE_L3_NEUTRAL 16'h7d41

// Powers
`define BMR_ACTIVE_POWER_PHASE1 16'h7d47
`define BMR_ACTIVE_POWER_PHASE2 16'h7d49
`define BMR_ACTIVE_POWER_PHASE3 16'h7d4b
`define BMR_ACTIVE_POWER_TOTAL 16'h7d4d
`define BMR_REACTIVE_POWER_PHASE1 16'h7d4f
`define BMR_REACTIVE_POWER_PHASE2 16'h7d51
`define BMR_REACTIVE_POWER_PHASE3 16'h7d53
`define BMR_REACTIVE_POWER_TOTAL 16'h7d55
`define BMR_APPARENT_POWER_PHASE1 16'h7d57
`define BMR_APPARENT_POWER_PHASE2 16'h7d59
`define BMR_APPARENT_POWER_PHASE3 16'h7d5b
`define BMR_APPARENT_POWER_TOTAL 16'h7d5d

// Energies and ground fault
`define BMR_ACTIVE_ENERGY_TOTAL 16'h7d5f
`define BMR_REACTIVE_ENERGY_TOTAL 16'h7d63
`define BMR_RESERVED_AFTER_ENERGY 16'h7d67
`define BMR_GROUND_FAULT_CURRENT 16'h7d95
`define BMR_RESERVED_AFTER_GROUND_FAULT 16'h7d97

// Demands
`define BMR_CURRENT_DEMAND_PHASE1 16'h7d9b
`define BMR_CURRENT_DEMAND_PHASE2 16'h7d9d
`define BMR_CURRENT_DEMAND_PHASE3 16'h7d9f
`define BMR_CURRENT_DEMAND_NEUTRAL 16'h7da1
`define BMR_ACTIVE_POWER_DEMAND_TOTAL 16'h7da3
`define BMR_REACTIVE_POWER_DEMAND_TOTAL 16'h7da5
`define BMR_APPARENT_POWER_DEMAND_TOTAL 16'h7da7
`define BMR_RESERVED_AFTER_DEMAND 16'h7da9

// Maximum voltages
`define BMR_MAX_VOLTAGE_L1_L2 16'h7dc1
`define BMR_MAX_VOLTAGE_L2_L3 16'h7dc3
`define BMR_MAX_VOLTAGE_L3_L1 16'h7dc5
`define BMR_MAX_VOLTAGE_L1_NEUTRAL 16'h7dc7
`define BMR_MAX_VOLTAGE_L2_NEUTRAL 16'h7dc9
`define BMR_MAX_VOLTAGE_L3_NEUTRAL 16'h7dcb

// System type codes
`define BMR_SYS_LN_A 8'h28
`define BMR_SYS_LN_B 8'h29
`define BMR_SYS_NEU_A 8'h1e

// Values and limits
`define BMR_INVALID_F32 32'hffc0_0000
`define BMR_RESET_WORD 16'h0000
`define BMR_MAX_READ 7'h7d

// Timing
`define BMR_CLK_HZ 40000000
`define BMR_SLIDE_PERIOD_S 15
`define BMR_SLIDE_CYCLES (`BMR_SLIDE_PERIOD_S * `BMR_CLK_HZ)

`endif

// file: hw/bmr_pkg.sv
package bmr_pkg;
   // Read engine states
   typedef enum logic {BMR_ST_IDLE, BMR_ST_SEND} bmr_state_e;
   // One single-precision measurement
   typedef logic [31:0] bmr_f32_t;
endpackage : bmr_pkg

// file: hw/bmr_max_tracker.sv
`timescale 1ns/1ps
module bmr_max_tracker import bmr_pkg::*; (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Sample and clear
   input wire logic sample_in,
   input wire logic clear_in,
   input wire bmr_f32_t value_in,
   // Held maximum
   output bmr_f32_t max_out
);
   bmr_f32_t max_q;

   // Peak hold; positive floats order like unsigned words
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         max_q <= '0;
      end else if (clear_in) begin
         max_q <= sample_in ? value_in : '0; // [R7]
      end else if (sample_in && (value_in > max_q)) begin
         max_q <= value_in; // [R7]
      end
   end

   assign max_out = max_q;

   // Checks on the held peak
   property p_max_rise;
      @(posedge mclk_in) disable iff (rst_in)
      (sample_in && !clear_in && (value_in > max_q)) |=> (max_q == $past(value_in));
   endproperty
   a_max_rise: assert property (p_max_rise) else $error("maximum missed a higher sample"); // [R7]

   property p_max_clear;
      @(posedge mclk_in) disable iff (rst_in)
      (clear_in && !sample_in) |=> (max_q == '0);
   endproperty
   a_max_clear: assert property (p_max_clear) else $error("maximum not cleared"); // [R7]

   property p_max_keep;
      @(posedge mclk_in) disable iff (rst_in)
      (!clear_in && !(sample_in && (value_in > max_q))) |=> $stable(max_q);
   endproperty
   a_max_keep: assert property (p_max_keep) else $error("maximum changed without cause"); // [R7]

   property p_max_set_wins;
      @(posedge mclk_in) disable iff (rst_in)
      (clear_in && sample_in) |=> (max_q == $past(value_in));
   endproperty
   a_max_set_wins: assert property (p_max_set_wins) else $error("sample lost to clear"); // [R7]
endmodule : bmr_max_tracker

// file: hw/bmr_regs.sv
`timescale 1ns/1ps
`include "bmr_defines.svh"
module bmr_regs import bmr_pkg::*; #(
   parameter int unsigned SLIDE_CYCLES = `BMR_SLIDE_CYCLES
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Live measurements
   input wire logic meas_strobe_in,
   input wire logic [2:0][31:0] volt_ll_in,
   input wire logic [2:0][31:0] volt_ln_in,
   input wire logic [2:0][31:0] p_phase_in,
   input wire bmr_f32_t p_total_in,
   input wire logic [2:0][31:0] q_phase_in,
   input wire bmr_f32_t q_total_in,
   input wire logic [2:0][31:0] s_phase_in,
   input wire bmr_f32_t s_total_in,
   input wire logic [63:0] active_energy_in,
   input wire logic [63:0] reactive_energy_in,
   input wire bmr_f32_t ground_fault_in,
   input wire logic [3:0][31:0] cur_demand_in,
   input wire logic [2:0][31:0] pwr_demand_in,
   // Configuration and commands
   input wire logic [7:0] system_type_in,
   input wire logic power_sign_in,
   input wire logic demand_sliding_in,
   input wire logic window_end_in,
   input wire logic max_reset_in,
   // Register read port
   input wire logic rd_start_in,
   input wire logic [15:0] rd_addr_in,
   input wire logic [6:0] rd_count_in,
   output logic [15:0] rd_data_out,
   output logic rd_valid_out,
   output logic rd_last_out,
   output logic rd_err_out,
   output logic rd_busy_out
);
   bmr_state_e st_q;
   logic [15:0] addr_q;
   logic [6:0] left_q;
   logic first_q;
   logic [63:0] snap_q;
   logic [31:0] slide_cnt_q;
   logic [31:0] gap_q;
   logic [2:0][31:0] dmd_q;
   logic [5:0][31:0] max_w;
   logic slide_tick;
   logic dmd_upd;
   logic ln_ok;
   logic nd_ok;
   logic [5:0][31:0] volt_view;
   logic [11:0][31:0] pwr_view;
   logic [6:0][31:0] dmd_view;
   logic [5:0][31:0] max_view;
   logic [63:0] item_val;
   logic [1:0] item_pos;
   logic item_hit;
   logic use_snap;
   logic [63:0] word_sh;
   logic [16:0] rd_end;
   logic rd_bad;

   // Flip the sign bit of a float when the sign setting asks
   function automatic bmr_f32_t bmr_sign(input bmr_f32_t v, input logic flip);
      return {v[31] ^ flip, v[30:0]};
   endfunction : bmr_sign

   // System type qualifiers
   assign ln_ok = (system_type_in == `BMR_SYS_LN_A) || (system_type_in == `BMR_SYS_LN_B);
   assign nd_ok = (system_type_in == `BMR_SYS_NEU_A) || (system_type_in == `BMR_SYS_LN_B);

   // Voltage maxima, one tracker per channel
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_max
         bmr_max_tracker u_max (
            .mclk_in(mclk_in),
            .rst_in(rst_in),
            .sample_in(meas_strobe_in),
            .clear_in(max_reset_in), // [R7]
            .value_in(gi < 3 ? volt_ll_in[gi % 3] : volt_ln_in[gi % 3]),
            .max_out(max_w[gi])
         );
      end
   endgenerate

   // Sliding window refresh timer
   always_ff @(posedge mclk_in) begin
      if (rst_in || !demand_sliding_in) begin
         slide_cnt_q <= '0;
      end else if (slide_cnt_q == SLIDE_CYCLES - 1) begin
         slide_cnt_q <= '0; // [R3]
      end else begin
         slide_cnt_q <= slide_cnt_q + 32'h1;
      end
   end

   assign slide_tick = demand_sliding_in && (slide_cnt_q == SLIDE_CYCLES - 1); // [R3]
   assign dmd_upd = demand_sliding_in ? slide_tick : window_end_in; // [R2] [R3]

   // Power demand registers, active and reactive signed at capture
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         dmd_q <= '0;
      end else if (dmd_upd) begin
         dmd_q[0] <= bmr_sign(pwr_demand_in[0], power_sign_in); // [R6]
         dmd_q[1] <= bmr_sign(pwr_demand_in[1], power_sign_in); // [R6]
         dmd_q[2] <= pwr_demand_in[2];
      end
   end

   // Cycles since the last demand refresh, read only by checks
   always_ff @(posedge mclk_in) begin
      if (rst_in || !demand_sliding_in || dmd_upd) begin
         gap_q <= '0;
      end else begin
         gap_q <= gap_q + 32'h1;
      end
   end

   // Readable views with validity and sign applied
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         volt_view[i] = volt_ll_in[i];
         volt_view[i + 3] = ln_ok ? volt_ln_in[i] : `BMR_INVALID_F32; // [R4]
         pwr_view[i] = ln_ok ? bmr_sign(p_phase_in[i], power_sign_in) : `BMR_INVALID_F32; // [R4] [R6]
         pwr_view[i + 4] = ln_ok ? bmr_sign(q_phase_in[i], power_sign_in) : `BMR_INVALID_F32; // [R4] [R6]
         pwr_view[i + 8] = ln_ok ? s_phase_in[i] : `BMR_INVALID_F32; // [R4]
         dmd_view[i] = cur_demand_in[i];
         dmd_view[i + 4] = dmd_q[i];
         max_view[i] = max_w[i];
         max_view[i + 3] = ln_ok ? max_w[i + 3] : `BMR_INVALID_F32; // [R4]
      end
      pwr_view[3] = bmr_sign(p_total_in, power_sign_in); // [R6]
      pwr_view[7] = bmr_sign(q_total_in, power_sign_in); // [R6]
      pwr_view[11] = s_total_in;
      dmd_view[3] = nd_ok ? cur_demand_in[3] : `BMR_INVALID_F32; // [R5]
   end

   // Address decode: value left aligned, word position within it
   always_comb begin
      logic [15:0] off;
      off = '0;
      item_hit = 1'b1;
      item_val = '0;
      item_pos = 2'h0;
      if ((addr_q < `BMR_ADDR_FIRST) || (addr_q > `BMR_ADDR_LAST)) begin
         item_hit = 1'b0;
      end else if (addr_q <= `BMR_VOLTAGE_L3_NEUTRAL + 16'h1) begin
         off = addr_q - `BMR_VOLTAGE_L1_L2;
         item_val = {volt_view[off[3:1]], 32'h0}; // [R8]
         item_pos = {1'b0, off[0]};
      end else if (addr_q < `BMR_ACTIVE_POWER_PHASE1) begin
         item_val = '0;
      end else if (addr_q <= `BMR_APPARENT_POWER_TOTAL + 16'h1) begin
         off = addr_q - `BMR_ACTIVE_POWER_PHASE1;
         item_val = {pwr_view[off[4:1]], 32'h0}; // [R8]
         item_pos = {1'b0, off[0]};
      end else if (addr_q <= `BMR_ACTIVE_ENERGY_TOTAL + 16'h3) begin
         off = addr_q - `BMR_ACTIVE_ENERGY_TOTAL;
         item_val = active_energy_in; // [R1]
         item_pos = off[1:0];
      end else if (addr_q <= `BMR_REACTIVE_ENERGY_TOTAL + 16'h3) begin
         off = addr_q - `BMR_REACTIVE_ENERGY_TOTAL;
         item_val = reactive_energy_in; // [R1]
         item_pos = off[1:0];
      end else if (addr_q < `BMR_GROUND_FAULT_CURRENT) begin
         item_val = '0;
      end else if (addr_q <= `BMR_GROUND_FAULT_CURRENT + 16'h1) begin
         off = addr_q - `BMR_GROUND_FAULT_CURRENT;
         item_val = {ground_fault_in, 32'h0};
         item_pos = {1'b0, off[0]};
      end else if (addr_q < `BMR_CURRENT_DEMAND_PHASE1) begin
         item_val = '0;
      end else if (addr_q <= `BMR_APPARENT_POWER_DEMAND_TOTAL + 16'h1) begin
         off = addr_q - `BMR_CURRENT_DEMAND_PHASE1;
         item_val = {dmd_view[off[3:1]], 32'h0};
         item_pos = {1'b0, off[0]};
      end else if (addr_q < `BMR_MAX_VOLTAGE_L1_L2) begin
         item_val = '0;
      end else begin
         off = addr_q - `BMR_MAX_VOLTAGE_L1_L2;
         item_val = {max_view[off[3:1]], 32'h0};
         item_pos = {1'b0, off[0]};
      end
   end

   // Later words of a value come from the copy taken at its first word
   assign use_snap = (item_pos != 2'h0) && !first_q; // [R8]
   assign word_sh = (use_snap ? snap_q : item_val) << {item_pos, 4'h0}; // [R1]

   // Request checks
   assign rd_end = {1'b0, rd_addr_in} + {10'h0, rd_count_in} - 17'h1;
   assign rd_bad = (rd_count_in == 7'h0) || (rd_count_in > `BMR_MAX_READ)
      || (rd_addr_in < `BMR_ADDR_FIRST) || (rd_end > {1'b0, `BMR_ADDR_LAST});

   // Read sequencer
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_q <= BMR_ST_IDLE;
         addr_q <= '0;
         left_q <= '0;
         first_q <= 1'b0;
      end else begin
         case (st_q)
            BMR_ST_IDLE: begin
               if (rd_start_in && !rd_bad) begin
                  st_q <= BMR_ST_SEND;
                  addr_q <= rd_addr_in;
                  left_q <= rd_count_in;
                  first_q <= 1'b1;
               end
            end
            BMR_ST_SEND: begin
               addr_q <= addr_q + 16'h1;
               left_q <= left_q - 7'h1;
               first_q <= 1'b0;
               if (left_q == 7'h1) begin
                  st_q <= BMR_ST_IDLE;
               end
            end
            default: begin
               st_q <= BMR_ST_IDLE;
            end
         endcase
      end
   end

   // Snapshot of the whole value on its first word
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         snap_q <= '0;
      end else if ((st_q == BMR_ST_SEND) && !use_snap) begin
         snap_q <= item_val; // [R8]
      end
   end

   // Registered read outputs
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rd_data_out <= `BMR_RESET_WORD;
         rd_valid_out <= 1'b0;
         rd_last_out <= 1'b0;
         rd_err_out <= 1'b0;
         rd_busy_out <= 1'b0;
      end else begin
         rd_valid_out <= (st_q == BMR_ST_SEND);
         rd_last_out <= (st_q == BMR_ST_SEND) && (left_q == 7'h1);
         rd_data_out <= (st_q == BMR_ST_SEND) ? word_sh[63:48] : `BMR_RESET_WORD; // [R1]
         rd_err_out <= (st_q == BMR_ST_IDLE) && rd_start_in && rd_bad;
         if (st_q == BMR_ST_IDLE) begin
            rd_busy_out <= rd_start_in && !rd_bad;
         end else begin
            rd_busy_out <= (left_q != 7'h1);
         end
      end
   end

   // Checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   property p_energy_msw;
      (st_q == BMR_ST_SEND) && (addr_q == `BMR_ACTIVE_ENERGY_TOTAL)
      |=> (rd_data_out == 16'($past(active_energy_in) >> 48));
   endproperty
   a_energy_msw: assert property (p_energy_msw) else $error("energy high word not first"); // [R1]

   property p_fixed_hold;
      (!demand_sliding_in && !window_end_in) |=> $stable(dmd_q);
   endproperty
   a_fixed_hold: assert property (p_fixed_hold) else $error("fixed demand moved mid window"); // [R2]

   property p_fixed_close;
      (!demand_sliding_in && window_end_in)
      |=> (dmd_q[2] == $past(pwr_demand_in[2]));
   endproperty
   a_fixed_close: assert property (p_fixed_close) else $error("demand missed window close"); // [R2]

   property p_slide_period;
      (demand_sliding_in && dmd_upd) |-> (gap_q == SLIDE_CYCLES - 1);
   endproperty
   a_slide_period: assert property (p_slide_period) else $error("sliding refresh off period"); // [R3]

   property p_slide_hold;
      (demand_sliding_in && (gap_q < SLIDE_CYCLES - 1)) |=> $stable(dmd_q);
   endproperty
   a_slide_hold: assert property (p_slide_hold) else $error("sliding demand moved early"); // [R3]

   property p_ln_invalid;
      (st_q == BMR_ST_SEND) && (addr_q == `BMR_VOLTAGE_L1_NEUTRAL) && !ln_ok
      |=> (rd_data_out == 16'(`BMR_INVALID_F32 >> 16));
   endproperty
   a_ln_invalid: assert property (p_ln_invalid) else $error("line-neutral value not invalid"); // [R4]

   property p_nd_invalid;
      (st_q == BMR_ST_SEND) && (addr_q == `BMR_CURRENT_DEMAND_NEUTRAL) && !nd_ok
      |=> (rd_data_out == 16'(`BMR_INVALID_F32 >> 16));
   endproperty
   a_nd_invalid: assert property (p_nd_invalid) else $error("neutral demand not invalid"); // [R5]

   property p_power_sign;
      (st_q == BMR_ST_SEND) && (addr_q == `BMR_ACTIVE_POWER_TOTAL)
      |=> (rd_data_out == ({$past(power_sign_in), 15'h0} ^ 16'($past(p_total_in) >> 16)));
   endproperty
   a_power_sign: assert property (p_power_sign) else $error("active power sign wrong"); // [R6]

   sequence s_hi_word;
      (st_q == BMR_ST_SEND) && (item_pos == 2'h0) && item_hit;
   endsequence

   sequence s_lo_word;
      (st_q == BMR_ST_SEND) && (item_pos == 2'h1);
   endsequence

   property p_pair_coherent;
      s_hi_word ##1 s_lo_word |=> (rd_data_out == 16'($past(snap_q) >> 32));
   endproperty
   a_pair_coherent: assert property (p_pair_coherent) else $error("float pair not coherent"); // [R8]

   // Read port handshake checks
   sequence s_take;
      (st_q == BMR_ST_IDLE) && rd_start_in && !rd_bad;
   endsequence

   sequence s_refuse;
      (st_q == BMR_ST_IDLE) && rd_start_in && rd_bad;
   endsequence

   property p_take_busy;
      s_take |=> (rd_busy_out && !rd_err_out && !rd_valid_out);
   endproperty
   a_take_busy: assert property (p_take_busy) else $error("accepted read not busy"); // [R8]

   property p_refuse_pulse;
      s_refuse |=> (rd_err_out && !rd_busy_out && !rd_valid_out);
   endproperty
   a_refuse_pulse: assert property (p_refuse_pulse) else $error("refusal not flagged"); // [R8]

   property p_last_drop;
      rd_last_out |-> (rd_valid_out && !rd_busy_out);
   endproperty
   a_last_drop: assert property (p_last_drop) else $error("busy outlived last word"); // [R8]

   // Reactive energy words leave high to low from one capture
   sequence s_react_start;
      (st_q == BMR_ST_SEND) && (addr_q == `BMR_REACTIVE_ENERGY_TOTAL) && (left_q >= 7'h4);
   endsequence

   property p_energy_order;
      s_react_start
      |=> (rd_data_out == 16'($past(reactive_energy_in) >> 48))
      ##1 (rd_data_out == 16'($past(reactive_energy_in, 2) >> 32))
      ##1 (rd_data_out == 16'($past(reactive_energy_in, 3) >> 16))
      ##1 (rd_data_out == 16'($past(reactive_energy_in, 4)));
   endproperty
   a_energy_order: assert property (p_energy_order) else $error("energy order wrong"); // [R1]
endmodule : bmr_regs

// file: tb/bmr_master.sv
`timescale 1ns/1ps
module bmr_master (
   // Clock
   input wire logic mclk_in,
   // Answer from the register block
   input wire logic [15:0] rd_data_in,
   input wire logic rd_valid_in,
   input wire logic rd_last_in,
   input wire logic rd_err_in,
   // Read request
   output logic rd_start_out,
   output logic [15:0] rd_addr_out,
   output logic [6:0] rd_count_out
);
   logic [15:0] words[$];
   logic err_seen;

   // Idle request lines at time zero
   initial begin
      rd_start_out = 1'b0;
      rd_addr_out = 16'h0000;
      rd_count_out = 7'h00;
   end

   // One transaction fetches every word of a value, so halves stay coherent
   task automatic read(input logic [15:0] a, input logic [6:0] n);
      int i;
      words.delete();
      err_seen = 1'b0;
      @(negedge mclk_in);
      rd_start_out = 1'b1;
      rd_addr_out = a;
      rd_count_out = n;
      @(negedge mclk_in);
      rd_start_out = 1'b0;
      rd_addr_out = ~a; // Released lines do not keep the old address
      rd_count_out = ~n;
      for (i = 0; i < 200; i++) begin
         if (rd_err_in === 1'b1) begin
            err_seen = 1'b1;
            break;
         end
         if (rd_valid_in === 1'b1) words.push_back(rd_data_in);
         if (rd_last_in === 1'b1) break;
         @(negedge mclk_in);
      end
   endtask : read
endmodule : bmr_master

// file: tb/bmr_regs_tb.sv
`timescale 1ns/1ps
`include "bmr_defines.svh"
module bmr_regs_tb;
   import bmr_pkg::*;
   localparam int unsigned SLIDE = 20;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic meas_strobe_in = 1'b0;
   logic [2:0][31:0] volt_ll_in = '0;
   logic [2:0][31:0] volt_ln_in = {32'h4300_0003, 32'h4300_0002, 32'h4300_0001};
   logic [2:0][31:0] p_phase_in = {32'h4200_0003, 32'h4200_0002, 32'h4200_0001};
   logic [2:0][31:0] q_phase_in = {32'h4100_0003, 32'h4100_0002, 32'hc000_0000};
   logic [2:0][31:0] s_phase_in = '0;
   logic [2:0][31:0] pwr_demand_in = '0;
   logic [3:0][31:0] cur_demand_in = {32'h4400_0004, 96'h0};
   bmr_f32_t p_total_in = 32'h4120_0000;
   bmr_f32_t q_total_in = 32'h4110_0000;
   bmr_f32_t s_total_in = 32'h4130_0000;
   bmr_f32_t ground_fault_in = 32'h3f80_0000;
   logic [63:0] active_energy_in = 64'hfedc_ba98_7654_3210;
   logic [63:0] reactive_energy_in = 64'h0123_4567_89ab_cdef;
   logic [7:0] system_type_in = 8'h28;
   logic power_sign_in = 1'b0;
   logic demand_sliding_in = 1'b0;
   logic window_end_in = 1'b0;
   logic max_reset_in = 1'b0;
   logic rd_start_in;
   logic [15:0] rd_addr_in;
   logic [6:0] rd_count_in;
   logic [15:0] rd_data_out;
   logic rd_valid_out;
   logic rd_last_out;
   logic rd_err_out;
   logic rd_busy_out;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   bmr_f32_t v;

   bmr_regs #(.SLIDE_CYCLES(SLIDE)) bmr_regs_i (.mclk_in(mclk_in), .rst_in(rst_in),
      .meas_strobe_in(meas_strobe_in), .volt_ll_in(volt_ll_in), .volt_ln_in(volt_ln_in),
      .p_phase_in(p_phase_in), .p_total_in(p_total_in), .q_phase_in(q_phase_in),
      .q_total_in(q_total_in), .s_phase_in(s_phase_in), .s_total_in(s_total_in),
      .active_energy_in(active_energy_in), .reactive_energy_in(reactive_energy_in),
      .ground_fault_in(ground_fault_in), .cur_demand_in(cur_demand_in),
      .pwr_demand_in(pwr_demand_in), .system_type_in(system_type_in),
      .power_sign_in(power_sign_in), .demand_sliding_in(demand_sliding_in),
      .window_end_in(window_end_in), .max_reset_in(max_reset_in),
      .rd_start_in(rd_start_in), .rd_addr_in(rd_addr_in), .rd_count_in(rd_count_in),
      .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .rd_last_out(rd_last_out),
      .rd_err_out(rd_err_out), .rd_busy_out(rd_busy_out));

   bmr_master bmr_master_i (.mclk_in(mclk_in), .rd_data_in(rd_data_out),
      .rd_valid_in(rd_valid_out), .rd_last_in(rd_last_out), .rd_err_in(rd_err_out),
      .rd_start_out(rd_start_in), .rd_addr_out(rd_addr_in), .rd_count_out(rd_count_in));

   // Clock and cycle ceiling
   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end

   // Compare and report
   task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Read one float value as a two-word transaction
   task automatic get32(input logic [15:0] a, output bmr_f32_t r);
      bmr_master_i.read(a, 7'h02);
      chk("word count", bmr_master_i.words.size(), 2);
      chk("no refusal", bmr_master_i.err_seen, 1'b0);
      chk("busy at last word", rd_busy_out, 1'b0);
      r = {bmr_master_i.words[0], bmr_master_i.words[1]};
   endtask : get32

   // One-cycle pulse on a control input
   task automatic pulse(ref logic s);
      @(negedge mclk_in);
      s = 1'b1;
      @(negedge mclk_in);
      s = 1'b0;
   endtask : pulse

   task automatic t_pairs_energy();
      volt_ll_in[0] = 32'h4366_8000;
      get32(`BMR_VOLTAGE_L1_L2, v);
      chk("voltage_l1_l2", v, 32'h4366_8000);
      fork
         bmr_master_i.read(`BMR_ACTIVE_ENERGY_TOTAL, 7'h08);
         begin
            repeat (2) @(negedge mclk_in);
            chk("busy mid read", rd_busy_out, 1'b1);
         end
      join
      chk("energy words", bmr_master_i.words.size(), 8);
      chk("active energy", {bmr_master_i.words[0], bmr_master_i.words[1],
         bmr_master_i.words[2], bmr_master_i.words[3]}, active_energy_in);
      chk("reactive energy", {bmr_master_i.words[4], bmr_master_i.words[5],
         bmr_master_i.words[6], bmr_master_i.words[7]}, reactive_energy_in);
      get32(`BMR_RESERVED_AFTER_ENERGY, v);
      chk("reserved", v, 32'h0);
   endtask : t_pairs_energy

   task automatic t_validity();
      logic [7:0] types[4];
      logic ln_ok;
      logic neu_ok;
      types = '{8'h28, 8'h29, 8'h1e, 8'h1f};
      foreach (types[k]) begin
         system_type_in = types[k];
         ln_ok = (types[k] == 8'h28) || (types[k] == 8'h29);
         neu_ok = (types[k] == 8'h1e) || (types[k] == 8'h29);
         get32(`BMR_VOLTAGE_L1_NEUTRAL, v);
         chk("l1 neutral", v, ln_ok ? volt_ln_in[0] : `BMR_INVALID_F32);
         get32(`BMR_ACTIVE_POWER_PHASE2, v);
         chk("p phase2", v, ln_ok ? p_phase_in[1] : `BMR_INVALID_F32);
         get32(`BMR_CURRENT_DEMAND_NEUTRAL, v);
         chk("neutral demand", v, neu_ok ? cur_demand_in[3] : `BMR_INVALID_F32);
      end
      system_type_in = 8'h28;
   endtask : t_validity

   task automatic t_sign();
      power_sign_in = 1'b1;
      bmr_master_i.read(`BMR_ACTIVE_POWER_TOTAL, 7'h04);
      chk("p total", {bmr_master_i.words[0], bmr_master_i.words[1]}, 32'hc120_0000);
      chk("q phase1", {bmr_master_i.words[2], bmr_master_i.words[3]}, 32'h4000_0000);
      get32(`BMR_APPARENT_POWER_TOTAL, v);
      chk("s total", v, s_total_in);
      power_sign_in = 1'b0;
   endtask : t_sign

   task automatic t_demand();
      pwr_demand_in[0] = 32'h4480_0000;
      get32(`BMR_ACTIVE_POWER_DEMAND_TOTAL, v);
      chk("p demand before close", v, 32'h0);
      pulse(window_end_in);
      get32(`BMR_ACTIVE_POWER_DEMAND_TOTAL, v);
      chk("p demand at close", v, 32'h4480_0000);
      demand_sliding_in = 1'b1;
      pwr_demand_in[0] = 32'h4490_0000;
      get32(`BMR_ACTIVE_POWER_DEMAND_TOTAL, v);
      chk("p demand mid period", v, 32'h4480_0000);
      repeat (SLIDE) @(negedge mclk_in);
      get32(`BMR_ACTIVE_POWER_DEMAND_TOTAL, v);
      chk("p demand after period", v, 32'h4490_0000);
      demand_sliding_in = 1'b0;
   endtask : t_demand

   task automatic t_maxima();
      volt_ll_in[0] = 32'h4400_0000;
      pulse(meas_strobe_in);
      volt_ll_in[0] = 32'h4300_0000;
      pulse(meas_strobe_in);
      get32(`BMR_MAX_VOLTAGE_L1_L2, v);
      chk("max l1_l2", v, 32'h4400_0000);
      pulse(max_reset_in);
      get32(`BMR_MAX_VOLTAGE_L1_L2, v);
      chk("max after reset", v, 32'h0);
      volt_ll_in[0] = 32'h4380_0000;
      @(negedge mclk_in);
      meas_strobe_in = 1'b1;
      max_reset_in = 1'b1;
      @(negedge mclk_in);
      meas_strobe_in = 1'b0;
      max_reset_in = 1'b0;
      get32(`BMR_MAX_VOLTAGE_L1_L2, v);
      chk("max set wins", v, 32'h4380_0000);
   endtask : t_maxima

   task automatic t_refused();
      bmr_master_i.read(16'h7d36, 7'h02);
      chk("below map", bmr_master_i.err_seen, 1'b1);
      bmr_master_i.read(16'h7dcc, 7'h02);
      chk("past map", bmr_master_i.err_seen, 1'b1);
      bmr_master_i.read(16'h7d37, 7'h00);
      chk("count zero", bmr_master_i.err_seen, 1'b1);
      bmr_master_i.read(16'h7d37, 7'h7e);
      chk("count over limit", bmr_master_i.err_seen, 1'b1);
   endtask : t_refused

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      repeat (3) @(negedge mclk_in);
      rst_in = 1'b0;
      t_pairs_energy();
      t_validity();
      t_sign();
      t_demand();
      t_maxima();
      t_refused();
      end_sim();
   end
endmodule : bmr_regs_tb
